// file: core/pacc_regs.svh
`ifndef PACC_REGS_SVH
`define PACC_REGS_SVH

// ----------------------------------------------------------------------------
// Register word offsets (byte address is four times the index).
// ----------------------------------------------------------------------------
`define PACC_IDX_ACC_LOW     4'h0
`define PACC_IDX_ACC_HIGH    4'h1
`define PACC_IDX_ACC_UPPER   4'h2
`define PACC_IDX_STEP_LOW    4'h3
`define PACC_IDX_STEP_HIGH   4'h4
`define PACC_IDX_STEP_UPPER  4'h5
`define PACC_IDX_CTRL        4'h6
`define PACC_IDX_IRQ_STATUS  4'h7
`define PACC_IDX_IRQ_ENABLE  4'h8
`define PACC_IDX_IRQ_CLEAR   4'h9

// ----------------------------------------------------------------------------
// Fields and reset values.
// ----------------------------------------------------------------------------
`define PACC_ACC_RESET       20'h0_0000
`define PACC_STEP_RESET      20'h0_0001
`define PACC_UPPER_MASK      8'h0F
`define PACC_CTRL_EN_BIT     0
`define PACC_IRQ_OVF_BIT     0
`define PACC_IRQ_MASK        8'h01
`define PACC_ZERO_BYTE       8'h00
`define PACC_ZERO_WORD       32'h0000_0000

`endif

// file: core/pacc_pkg.sv
package pacc_pkg;

    typedef struct packed {
        logic [3:0] upper;
        logic [7:0] high;
        logic [7:0] low;
    } pacc_word_t;

    typedef enum logic [1:0] {
        PACC_BUS_IDLE,
        PACC_BUS_ANSWER
    } pacc_bus_state_t;

endpackage

// file: core/pacc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-flop sampler of the oscillator input clock with edge strobes.
// ----------------------------------------------------------------------------
module pacc_edge_sync (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic level_in,
    output logic      rise_out,
    output logic      fall_out
);

    logic meta;
    logic stable;
    logic prev;

    // The first stage feeds only the second, so edge logic never sees a metastable value.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
        end else begin
            meta   <= level_in;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign rise_out = stable & ~prev;
    assign fall_out = ~stable & prev;

endmodule

`default_nettype wire

// file: core/pacc_top.sv
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pacc_regs.svh"

module pacc_top #(
    parameter int ACC_WIDTH = 20
) (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [5:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        osc_input_clock_in,
    output logic             osc_enable_out,
    output logic             accum_carry_out,
    output logic             irq_out
);

    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    pacc_pkg::pacc_word_t      phase_accum;
    pacc_pkg::pacc_word_t      phase_step;
    logic [ACC_WIDTH-1:0]      step_working_buffer;
    logic                      osc_enable;
    logic                      overflow_irq_flag;
    logic                      irq_enable;
    logic                      load_pending;
    logic                      osc_rise;
    logic                      osc_fall;
    pacc_pkg::pacc_bus_state_t bus_state;
    logic [ACC_WIDTH:0]        next_sum;
    logic                      wr_take;
    logic                      rd_take;
    logic [3:0]                reg_index;
    logic [7:0]                wbyte;

    function automatic logic hit(input logic [3:0] idx, input logic [3:0] want);
        hit = (idx == want);
    endfunction

    pacc_edge_sync u_edge (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .level_in (osc_input_clock_in),
        .rise_out (osc_rise),
        .fall_out (osc_fall)
    );

    // ------------------------------------------------------------------------
    // Bus handshake: one wait cycle, answered in the second.
    // ------------------------------------------------------------------------
    assign reg_index = avs_address_in[5:2];
    assign wbyte     = avs_writedata_in[7:0];
    assign wr_take   = avs_write_in & (bus_state == pacc_pkg::PACC_BUS_ANSWER);
    assign rd_take   = avs_read_in & (bus_state == pacc_pkg::PACC_BUS_ANSWER);
    assign avs_waitrequest_out = (avs_read_in | avs_write_in)
                                 & (bus_state != pacc_pkg::PACC_BUS_ANSWER);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bus_state <= pacc_pkg::PACC_BUS_IDLE;
        end else begin
            case (bus_state)
                pacc_pkg::PACC_BUS_IDLE: begin
                    if (avs_read_in | avs_write_in) begin
                        bus_state <= pacc_pkg::PACC_BUS_ANSWER;
                    end
                end
                pacc_pkg::PACC_BUS_ANSWER: begin
                    bus_state <= pacc_pkg::PACC_BUS_IDLE;
                end
                default: begin
                    bus_state <= pacc_pkg::PACC_BUS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Control and step registers.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            osc_enable <= 1'b0;
            irq_enable <= 1'b0;
        end else if (wr_take & avs_byteenable_in[0]) begin
            if (hit(reg_index, `PACC_IDX_CTRL)) begin
                osc_enable <= wbyte[`PACC_CTRL_EN_BIT];
            end
            if (hit(reg_index, `PACC_IDX_IRQ_ENABLE)) begin
                irq_enable <= wbyte[`PACC_IRQ_OVF_BIT];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_step <= `PACC_STEP_RESET;
        end else if (wr_take & avs_byteenable_in[0]) begin
            if (hit(reg_index, `PACC_IDX_STEP_LOW)) begin
                phase_step.low <= wbyte;
            end
            if (hit(reg_index, `PACC_IDX_STEP_HIGH)) begin
                phase_step.high <= wbyte;
            end
            if (hit(reg_index, `PACC_IDX_STEP_UPPER)) begin
                phase_step.upper <= wbyte[3:0];
            end
        end
    end

    chk_step_low_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_STEP_LOW))
        |=> (phase_step.low == $past(wbyte)))
        else $error("Step low byte write was lost.");

    chk_step_high_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_STEP_HIGH))
        |=> (phase_step.high == $past(wbyte)))
        else $error("Step high byte write was lost.");

    chk_step_upper_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_STEP_UPPER))
        |=> (phase_step.upper == $past(wbyte[3:0])))
        else $error("Step upper nibble write was lost.");

    chk_step_held: assert property (@(posedge clk_in) disable iff (reset_in)
        ~wr_take |=> $stable(phase_step))
        else $error("Step changed without a register write.");

    // ------------------------------------------------------------------------
    // Working buffer. While enabled, a write to the low byte arms a load that happens on the
    // next falling input edge, so the adder never sees a half-written step.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            load_pending <= 1'b0;
        end else if (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_STEP_LOW)
                     & osc_enable) begin
            load_pending <= 1'b1;
        end else if (osc_fall | ~osc_enable) begin
            load_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            step_working_buffer <= `PACC_STEP_RESET;
        end else if (~osc_enable) begin
            step_working_buffer <= phase_step;
        end else if (load_pending & osc_fall) begin
            step_working_buffer <= phase_step;
        end
    end

    chk_arm_on_low: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_STEP_LOW) & osc_enable)
        |=> load_pending)
        else $error("Low step write did not arm the buffer load.");

    chk_load_on_fall: assert property (@(posedge clk_in) disable iff (reset_in)
        (load_pending & osc_fall) |=> (step_working_buffer == $past(phase_step)))
        else $error("Working buffer missed its falling edge load.");

    // ------------------------------------------------------------------------
    // Accumulator. A software write taken in the same cycle as a rise while running collides with the adder;
    // the adder wins and the byte write in that cycle is dropped.
    // ------------------------------------------------------------------------
    assign next_sum = {1'b0, phase_accum} + {1'b0, step_working_buffer};

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_accum <= `PACC_ACC_RESET;
        end else if (osc_enable & osc_rise) begin
            phase_accum <= next_sum[ACC_WIDTH-1:0];
        end else if (wr_take & avs_byteenable_in[0]) begin
            if (hit(reg_index, `PACC_IDX_ACC_LOW)) begin
                phase_accum.low <= wbyte;
            end
            if (hit(reg_index, `PACC_IDX_ACC_HIGH)) begin
                phase_accum.high <= wbyte;
            end
            if (hit(reg_index, `PACC_IDX_ACC_UPPER)) begin
                phase_accum.upper <= wbyte[3:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            accum_carry_out <= 1'b0;
        end else begin
            accum_carry_out <= osc_enable & osc_rise & next_sum[ACC_WIDTH];
        end
    end

    chk_acc_low_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_ACC_LOW)
         & ~(osc_enable & osc_rise)) |=> (phase_accum.low == $past(wbyte)))
        else $error("Accumulator low byte write was lost.");

    chk_acc_high_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_ACC_HIGH)
         & ~(osc_enable & osc_rise)) |=> (phase_accum.high == $past(wbyte)))
        else $error("Accumulator high byte write was lost.");

    chk_acc_upper_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_ACC_UPPER)
         & ~(osc_enable & osc_rise)) |=> (phase_accum.upper == $past(wbyte[3:0])))
        else $error("Accumulator upper nibble write was lost.");

    chk_acc_held: assert property (@(posedge clk_in) disable iff (reset_in)
        (~(osc_enable & osc_rise) & ~wr_take) |=> $stable(phase_accum))
        else $error("Accumulator moved without a rise or a write.");

    chk_carry_origin: assert property (@(posedge clk_in) disable iff (reset_in)
        accum_carry_out |-> $past(osc_enable & osc_rise & next_sum[ACC_WIDTH]))
        else $error("Carry out without an overflow.");

    // ------------------------------------------------------------------------
    // Interrupt: a carry in the same cycle as a clear keeps the flag set.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            overflow_irq_flag <= 1'b0;
        end else if (accum_carry_out) begin
            overflow_irq_flag <= 1'b1;
        end else if (wr_take & avs_byteenable_in[0] & hit(reg_index, `PACC_IDX_IRQ_CLEAR)
                     & wbyte[`PACC_IRQ_OVF_BIT]) begin
            overflow_irq_flag <= 1'b0;
        end
    end

    assign irq_out        = overflow_irq_flag & irq_enable;
    assign osc_enable_out = osc_enable;

    chk_flag_clear: assert property (@(posedge clk_in) disable iff (reset_in)
        (~accum_carry_out & wr_take & avs_byteenable_in[0]
         & hit(reg_index, `PACC_IDX_IRQ_CLEAR) & wbyte[`PACC_IRQ_OVF_BIT])
        |=> ~overflow_irq_flag)
        else $error("Overflow flag survived a clear.");

    chk_flag_origin: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(overflow_irq_flag) |-> $past(accum_carry_out))
        else $error("Overflow flag set without a carry.");

    // ------------------------------------------------------------------------
    // Read data. Bytes are sampled one at a time, so a 20-bit read can tear.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            avs_readdata_out <= `PACC_ZERO_WORD;
        end else if (avs_read_in & (bus_state == pacc_pkg::PACC_BUS_IDLE)) begin
            case (reg_index)
                `PACC_IDX_ACC_LOW:    avs_readdata_out <= {24'h00_0000, phase_accum.low};
                `PACC_IDX_ACC_HIGH:   avs_readdata_out <= {24'h00_0000, phase_accum.high};
                `PACC_IDX_ACC_UPPER:  avs_readdata_out <= {28'h000_0000, phase_accum.upper};
                `PACC_IDX_STEP_LOW:   avs_readdata_out <= {24'h00_0000, phase_step.low};
                `PACC_IDX_STEP_HIGH:  avs_readdata_out <= {24'h00_0000, phase_step.high};
                `PACC_IDX_STEP_UPPER: avs_readdata_out <= {28'h000_0000, phase_step.upper};
                `PACC_IDX_CTRL:       avs_readdata_out <= {31'h0000_0000, osc_enable};
                `PACC_IDX_IRQ_STATUS: avs_readdata_out <= {31'h0000_0000, overflow_irq_flag};
                `PACC_IDX_IRQ_ENABLE: avs_readdata_out <= {31'h0000_0000, irq_enable};
                default:              avs_readdata_out <= `PACC_ZERO_WORD;
            endcase
        end
    end

    chk_read_step_low: assert property (@(posedge clk_in) disable iff (reset_in)
        (rd_take & $past(avs_read_in) & $stable(reg_index)
         & hit(reg_index, `PACC_IDX_STEP_LOW))
        |-> (avs_readdata_out == {24'h00_0000, $past(phase_step.low)}))
        else $error("Step low byte read back wrong.");

    chk_read_acc_low: assert property (@(posedge clk_in) disable iff (reset_in)
        (rd_take & $past(avs_read_in) & $stable(reg_index)
         & hit(reg_index, `PACC_IDX_ACC_LOW))
        |-> (avs_readdata_out == {24'h00_0000, $past(phase_accum.low)}))
        else $error("Accumulator low byte read back wrong.");

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    chk_acc_adds_step: assert property (@(posedge clk_in) disable iff (reset_in)
        (osc_enable & osc_rise) |=> (phase_accum == $past(next_sum[ACC_WIDTH-1:0])))
        else $error("Accumulator did not add the working step.");

    chk_carry_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
        (osc_enable & osc_rise & next_sum[ACC_WIDTH]) |=> accum_carry_out)
        else $error("Carry out missing after overflow.");

    chk_flag_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
        accum_carry_out |=> overflow_irq_flag)
        else $error("Overflow flag not set after carry.");

    chk_flag_holds: assert property (@(posedge clk_in) disable iff (reset_in)
        (overflow_irq_flag & ~(wr_take & hit(reg_index, `PACC_IDX_IRQ_CLEAR)))
        |=> overflow_irq_flag)
        else $error("Overflow flag dropped without a clear.");

    chk_buffer_immediate: assert property (@(posedge clk_in) disable iff (reset_in)
        ~osc_enable |=> (step_working_buffer == $past(phase_step)))
        else $error("Disabled buffer did not track the step.");

    chk_buffer_waits: assert property (@(posedge clk_in) disable iff (reset_in)
        (osc_enable & $past(osc_enable) & ~$past(osc_fall))
        |-> $stable(step_working_buffer))
        else $error("Working buffer changed without a falling edge.");

    chk_upper_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        (bus_state == pacc_pkg::PACC_BUS_ANSWER) & avs_read_in
        & (hit(reg_index, `PACC_IDX_ACC_UPPER) | hit(reg_index, `PACC_IDX_STEP_UPPER))
        |-> (avs_readdata_out[7:4] == 4'h0))
        else $error("Upper byte high nibble not zero.");

    chk_step_reset: assert property (@(posedge clk_in)
        $past(reset_in) |-> (phase_step == `PACC_STEP_RESET)
        && (step_working_buffer == `PACC_STEP_RESET))
        else $error("Step did not reset to one.");

    chk_acc_reset: assert property (@(posedge clk_in)
        $past(reset_in) |-> (phase_accum == `PACC_ACC_RESET))
        else $error("Accumulator did not reset to zero.");

endmodule

`default_nettype wire

// file: verification/pacc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pacc_regs.svh"

// ----------------------------------------------------------------------------
// Register bus and oscillator stimulus with queued read expectations.
// ----------------------------------------------------------------------------
module pacc_top_test;
    logic        clk_in;
    logic        reset_in;
    logic [5:0]  avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        osc_input_clock_in;
    logic        osc_enable_out;
    logic        accum_carry_out;
    logic        irq_out;
    logic [31:0] exp_q[$];
    int          n_mismatch;
    int          cmp_count;
    int          cycles;
    int          carry_seen;
    int          exp_carries;
    int          seed;
    int          i;
    logic [19:0] exp_acc;
    logic [19:0] s1;
    logic [19:0] s2;
    logic [31:0] rnd;

    pacc_top #(.ACC_WIDTH(20)) dut (
        .clk_in              (clk_in),
        .reset_in            (reset_in),
        .avs_address_in      (avs_address_in),
        .avs_read_in         (avs_read_in),
        .avs_write_in        (avs_write_in),
        .avs_writedata_in    (avs_writedata_in),
        .avs_byteenable_in   (avs_byteenable_in),
        .avs_readdata_out    (avs_readdata_out),
        .avs_waitrequest_out (avs_waitrequest_out),
        .osc_input_clock_in  (osc_input_clock_in),
        .osc_enable_out      (osc_enable_out),
        .accum_carry_out     (accum_carry_out),
        .irq_out             (irq_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Bus master: one request held until waitrequest is seen low.
    // ------------------------------------------------------------------------
    // The edge at the start of each call keeps strobes from being driven twice
    // in one time step when transfers follow each other.
    task automatic bus_xfer(input logic wr, input logic [3:0] idx, input logic [7:0] data,
                            input logic [3:0] be);
        @(posedge clk_in);
        avs_address_in    <= {idx, 2'b00};
        avs_writedata_in  <= {24'h00_0000, data};
        avs_byteenable_in <= be;
        avs_read_in       <= ~wr;
        avs_write_in      <= wr;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] data);
        bus_xfer(1'b1, idx, data, 4'h1);
    endtask

    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        exp_q.push_back({24'h00_0000, exp});
        bus_xfer(1'b0, idx, 8'h00, 4'h1);
    endtask

    task automatic load3(input logic [3:0] base, input logic [23:0] v);
        wr(base + 4'h2, v[23:16]);
        wr(base + 4'h1, v[15:8]);
        wr(base, v[7:0]);
    endtask

    task automatic read3(input logic [3:0] base, input logic [23:0] v);
        rd(base, v[7:0]);
        rd(base + 4'h1, v[15:8]);
        rd(base + 4'h2, v[23:16] & 8'h0F);
    endtask

    task automatic reset_check;
        for (i = 0; i <= 10; i++) begin
            if (i != 9) rd(i[3:0], (i == 3) ? 8'h01 : 8'h00);
        end
    endtask

    // The model adds each step at the rise, as the design should.
    task automatic pulses(input int n, input logic [19:0] step);
        logic [20:0] sum;
        repeat (n) begin
            @(posedge clk_in);
            osc_input_clock_in <= 1'b1;
            sum = {1'b0, exp_acc} + {1'b0, step};
            exp_acc = sum[19:0];
            exp_carries += int'(sum[20]);
            repeat (4) @(posedge clk_in);
            osc_input_clock_in <= 1'b0;
            repeat (4) @(posedge clk_in);
        end
    endtask

    // ------------------------------------------------------------------------
    // Output watcher and hang limit.
    // ------------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
            check(avs_readdata_out, exp_q.pop_front());
        end
        if (accum_carry_out === 1'b1) carry_seen++;
    end

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        seed = 49;
        cycles = 0;
        n_mismatch = 0;
        cmp_count = 0;
        carry_seen = 0;
        exp_carries = 0;
        reset_in = 1'b1;
        avs_address_in = 6'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0000_0000;
        avs_byteenable_in = 4'h1;
        osc_input_clock_in = 1'b0;
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        reset_check();
        rnd = $random(seed);
        load3(4'h0, rnd[23:0]);
        read3(4'h0, rnd[23:0]);
        rnd = $random(seed);
        load3(4'h3, rnd[23:0]);
        read3(4'h3, rnd[23:0]);
        bus_xfer(1'b1, 4'h3, ~rnd[7:0], 4'h0);
        rd(4'h3, rnd[7:0]);
        wr(4'hB, 8'hFF);
        rd(4'hB, 8'h00);
        rnd = $random(seed);
        s1 = {4'h0, rnd[15:0]} | 20'h0_0010;
        load3(4'h3, {4'h0, s1});
        exp_acc = 20'hF_FFF0;
        load3(4'h0, 24'h0F_FFF0);
        wr(4'h8, 8'h01);
        wr(4'h6, 8'h01);
        rd(4'h6, 8'h01);
        check(32'(osc_enable_out), 32'h0000_0001);
        pulses(3, s1);
        rnd = $random(seed);
        s2 = rnd[19:0];
        load3(4'h3, {4'h0, s2});
        pulses(1, s1);
        pulses(2, s2);
        wr(4'h6, 8'h00);
        repeat (4) @(posedge clk_in);
        read3(4'h0, {4'h0, exp_acc});
        check(carry_seen, exp_carries);
        @(negedge clk_in);
        check(32'(irq_out), 32'h0000_0001);
        wr(4'h8, 8'h00);
        @(negedge clk_in);
        check(32'(irq_out), 32'h0000_0000);
        wr(4'h7, 8'h00);
        rd(4'h7, 8'h01);
        wr(4'h8, 8'h01);
        wr(4'h9, 8'h01);
        rd(4'h7, 8'h00);
        @(negedge clk_in);
        check(32'(irq_out), 32'h0000_0000);
        // A second reset in mid-run must restore every reset value.
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        reset_check();
        exp_acc = 20'h0_0000;
        wr(4'h6, 8'h01);
        pulses(1, 20'h0_0001);
        wr(4'h6, 8'h00);
        repeat (4) @(posedge clk_in);
        read3(4'h0, {4'h0, exp_acc});
        repeat (4) @(posedge clk_in);
        check(exp_q.size(), 32'h0000_0000);
        end_of_test();
    end
endmodule

`default_nettype wire
